// ===== testbench/pdic_partner.sv
// far-side model: instruction buffer queue, register file and result returns
// assumes the decoder samples parcels and register selects on clock_i rising edges
`default_nettype none
module pdic_partner
  import pdic_pkg::*;
(
  // clock and reset
  input wire logic clock_i,
  input wire logic resetn_i,
  // parcel supply
  output logic parcel_valid_o,
  output logic [15:0] parcel_o,
  output logic [23:0] parcel_addr_o,
  input wire logic parcel_ready_i,
  // register file
  input wire logic [63:0] seed_i,
  input wire logic [2:0] h_sel_i,
  input wire logic [2:0] i_sel_i,
  input wire logic [2:0] j_sel_i,
  input wire logic [2:0] k_sel_i,
  output logic [63:0] rf_h_o,
  output logic [63:0] rf_i_o,
  output logic [63:0] rf_j_o,
  output logic [63:0] rf_k_o,
  // issue and result returns
  input wire logic iss_valid_i,
  input wire logic [6:0] iss_opcode_i,
  input wire logic [2:0] iss_dest_i,
  output logic [7:0] a_done_o,
  output logic [7:0] s_done_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] q[$];
  logic [7:0] a_d;
  logic [7:0] s_d;
  logic acls;
  function automatic logic [63:0] rfv(input logic [2:0] s);
    return seed_i ^ ({61'h0, s} * 64'h0101_0101_0101_0101);
  endfunction : rfv
  task automatic push(input logic [15:0] p);
    q.push_back(p);
  endtask : push
  assign rf_h_o = rfv(h_sel_i);
  assign rf_i_o = rfv(i_sel_i);
  assign rf_j_o = rfv(j_sel_i);
  assign rf_k_o = rfv(k_sel_i);
  // ==========================================================
  // parcel supply: one parcel per accepted edge, line toggles when idle
  always @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      parcel_valid_o <= 1'b0;
      parcel_o <= 16'h0;
      parcel_addr_o <= 24'h0;
    end else if (!parcel_valid_o || parcel_ready_i) begin
      if (parcel_valid_o) parcel_addr_o <= parcel_addr_o + 24'h1;
      if (q.size() > 0) begin
        parcel_valid_o <= 1'b1;
        parcel_o <= q.pop_front();
      end else begin
        parcel_valid_o <= 1'b0;
        parcel_o <= ~parcel_o;
      end
    end
  end
  // ==========================================================
  // results land two cycles after issue and free the reservation
  assign acls = (iss_opcode_i <= 7'h1f) || (iss_opcode_i[6:4] == 3'h4);
  always @(posedge clock_i) begin
    a_d <= (resetn_i && iss_valid_i && acls) ? 8'h1 << iss_dest_i : 8'h0;
    s_d <= (resetn_i && iss_valid_i && !acls) ? 8'h1 << iss_dest_i : 8'h0;
    a_done_o <= a_d;
    s_done_o <= s_d;
  end
endmodule : pdic_partner
`default_nettype wire

// ===== testbench/tb_parcel_decode_issue_control.sv
// self-checking bench: parcel stream against a queue model of issued instructions
// assumes pdic_decoder with default parameters and the pdic_partner far side
`default_nettype none
module tb_parcel_decode_issue_control;
  import pdic_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct {
    logic [6:0] op; logic [2:0] fmt; logic [2:0] dst; logic [23:0] imm;
    logic vr; logic two; logic mem; logic [63:0] oh, oi, oj, ok;
  } pdic_exp_s;
  logic clock_i = 1'b0;
  logic resetn_i = 1'b0;
  logic [2:0] adr = 3'h0;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wd = 32'h0;
  logic [31:0] rdat, rdv;
  logic wt;
  logic pv, pr;
  logic [15:0] pd;
  logic [23:0] pa;
  logic [2:0] hs, is, js, ks, dst, fmt;
  logic [63:0] rh, ri, rj, rk, oh, oi, oj, ok;
  logic [63:0] seed_r = 64'h0;
  logic [31:0] sema = 32'h0;
  logic [7:0] ad, sd;
  logic iv, vl, tw, ss, xc;
  logic [6:0] op;
  logic [23:0] imm, xa;
  logic [5:0] sidx;
  integer seed = 96222;
  integer mismatches = 0;
  integer tests_run = 0;
  integer np = 0;
  integer ni = 0;
  logic busy = 1'b0;
  logic bq = 1'b0;
  logic held = 1'b0;
  logic intr = 1'b0;
  pdic_exp_s eq[$];
  pdic_exp_s e;
  always #12.5 clock_i = ~clock_i;
  pdic_decoder pdic_decoder_inst (.clock_i(clock_i), .resetn_i(resetn_i),
    .avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd),
    .avs_byteenable_i(4'hf), .avs_readdata_o(rdat), .avs_waitrequest_o(wt),
    .parcel_valid_i(pv), .parcel_i(pd), .parcel_addr_i(pa), .parcel_ready_o(pr),
    .rd_h_sel_o(hs), .rd_i_sel_o(is), .rd_j_sel_o(js), .rd_k_sel_o(ks),
    .rf_h_i(rh), .rf_i_i(ri), .rf_j_i(rj), .rf_k_i(rk), .unit_busy_i(busy),
    .a_done_i(ad), .s_done_i(sd), .iss_valid_o(iv), .iss_opcode_o(op),
    .iss_fmt_o(fmt), .iss_dest_o(dst), .iss_imm_o(imm), .iss_var_lat_o(vl),
    .op_h_o(oh), .op_i_o(oi), .op_j_o(oj), .op_k_o(ok), .sema_i(sema),
    .all_held_i(held), .intr_i(intr), .tas_wait_o(tw), .sema_set_o(ss),
    .sema_idx_o(sidx), .xchg_o(xc), .xchg_addr_o(xa));
  pdic_partner pdic_partner_inst (.clock_i(clock_i), .resetn_i(resetn_i),
    .parcel_valid_o(pv), .parcel_o(pd), .parcel_addr_o(pa), .parcel_ready_i(pr),
    .seed_i(seed_r), .h_sel_i(hs), .i_sel_i(is), .j_sel_i(js), .k_sel_i(ks),
    .rf_h_o(rh), .rf_i_o(ri), .rf_j_o(rj), .rf_k_o(rk), .iss_valid_i(iv),
    .iss_opcode_i(op), .iss_dest_i(dst), .a_done_o(ad), .s_done_o(sd));
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic close_out;
    $display("mismatches=%0d tests_run=%0d", mismatches, tests_run);
    if (mismatches == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : close_out
  task automatic bus(input logic w, input logic [2:0] a, input logic [31:0] d);
    @(posedge clock_i);
    adr <= a;
    wd <= d;
    rd <= !w;
    wr <= w;
    do @(posedge clock_i); while (wt !== 1'b0);
    rdv = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask : bus
  function automatic logic [63:0] rfv(input logic [2:0] s);
    return seed_r ^ ({61'h0, s} * 64'h0101_0101_0101_0101);
  endfunction : rfv
  // model: decode a parcel pair into the expected issue record
  task automatic put(input logic [15:0] p, input logic [15:0] m);
    pdic_exp_s x;
    logic [2:0] h, i, j, k;
    logic br;
    {x.op, i, j, k} = p;
    h = p[11:9];
    x.mem = p[15:14] == 2'h2;
    br = x.op >= 7'h06 && x.op <= 7'h0f;
    x.two = x.mem || x.op == 7'h10 || x.op == 7'h20 || br;
    x.fmt = br ? (i[2] ? 3'h4 : 3'h3) : 3'h2;
    x.imm = br ? {i[1:0], j, k, m} : {2'h0, j, k, m};
    x.dst = (br && i[2]) ? h : i;
    x.vr = x.mem || x.op <= 7'h0f;
    x.oh = h == 3'h0 ? ZERO_OPND : rfv(h);
    x.oi = rfv(i);
    x.oj = j == 3'h0 ? ZERO_OPND : rfv(j);
    x.ok = k != 3'h0 ? rfv(k) : x.op[6:4] == 3'h1 ? AK_ZERO_OPND : SK_ZERO_OPND;
    eq.push_back(x);
    np += x.two ? 2 : 1;
    ni++;
    pdic_partner_inst.push(p);
    if (x.two) pdic_partner_inst.push(m);
  endtask : put
  // held test-and-set ended by interrupt (ih) or by the whole cluster stalling
  task automatic tas_x(input logic ih, input logic [31:0] fl);
    int a;
    a = np;
    sema <= 32'h20;
    intr <= ih;
    held <= !ih;
    put({7'h03, 3'h4, 6'h05}, 16'h0);
    void'(eq.pop_back());
    for (int n = 0; n < 50 && xc !== 1'b1; n++) @(posedge clock_i);
    chk({xc, xa}, {1'b1, a[23:0]});
    intr <= 1'b0;
    held <= 1'b0;
    sema <= 32'h0;
    bus(1'b0, REG_XFLAGS, 32'h0);
    chk(rdv, fl);
    bus(1'b1, REG_XFLAGS, 32'h3);
  endtask : tas_x
  // random unit-busy holds; bq is the level seen in the issue cycle
  always @(posedge clock_i) begin
    busy <= ($random(seed) & 3) == 0;
    bq <= busy;
  end
  // ==========================================================
  // compare every issued instruction other than test-and-set with the model
  always @(posedge clock_i) begin
    if (resetn_i && iv === 1'b1 && op !== OP_TAS) begin
      if (eq.size() == 0) chk(1'b1, 1'b0);
      else begin
        e = eq.pop_front();
        chk(bq, 1'b0);
        chk(op, e.op);
        chk(dst, e.dst);
        chk(vl, e.vr);
        if (e.two) chk({fmt, imm}, {e.fmt, e.imm});
        if (e.mem) chk(oh, e.oh);
        if (!e.two) chk(oi, e.oi);
        if (!e.two) chk({oj, ok}, {e.oj, e.ok});
      end
    end
  end
  initial begin
    repeat (20000) @(posedge clock_i);
    mismatches++;
    close_out();
  end
  initial begin
    seed_r = {$random(seed), $random(seed)};
    repeat (16) @(posedge clock_i);
    resetn_i <= 1'b1;
    bus(1'b0, REG_CTRL, 32'h0);
    chk(rdv, 32'h2);
    bus(1'b0, 3'h5, 32'h0);
    chk(rdv, 32'h0);
    bus(1'b1, REG_CTRL, 32'h3);
    bus(1'b0, REG_CTRL, 32'h0);
    chk(rdv, 32'h3);
    bus(1'b1, REG_CTRL, 32'h2);
    for (int n = 0; n < 12; n++) begin
      put({n[0] ? 7'h30 : 7'h18, 9'($random(seed)) & (n < 2 ? 9'h0 : 9'h1ff)}, 16'h0);
      put({4'h8 + n[1:0], 12'($random(seed))}, 16'($random(seed)));
      put({n[0] ? 7'h10 : 7'h20, 9'($random(seed))}, 16'($random(seed)));
      put({7'h06 + n[2:0], 9'($random(seed))}, 16'($random(seed)));
    end
    for (int n = 0; n < 1000 && eq.size() > 0; n++) @(posedge clock_i);
    chk(eq.size(), 0);
    sema <= 32'h20;
    put({7'h03, 3'h4, 6'h05}, 16'h0);
    void'(eq.pop_back());
    repeat (12) @(posedge clock_i);
    chk(tw, 1'b1);
    sema <= 32'h0;
    for (int n = 0; n < 50 && ss !== 1'b1; n++) @(posedge clock_i);
    chk({ss, sidx}, {1'b1, 6'h05});
    bus(1'b0, REG_ISSUED, 32'h0);
    chk(rdv, ni);
    tas_x(1'b1, 32'h2);
    tas_x(1'b0, 32'h1);
    bus(1'b1, REG_CTRL, 32'h3);
    tas_x(1'b0, 32'h0);
    bus(1'b0, REG_STATUS, 32'h0);
    chk(rdv, 32'h0);
    close_out();
  end
endmodule : tb_parcel_decode_issue_control
`default_nettype wire

// ===== verilog/pdic_decoder.sv
// parcel pipeline, field decode, register-zero substitution and issue control
// assumes parcel source, register file and result returns share clock_i;
// semaphore, cluster-held and interrupt inputs are asynchronous pins
//
// Contract
// - instructions are one or two 16-bit parcels
// - four parcels per word, any addressable
// - two-parcel instruction may cross word boundary
// - fields g4 h3 i3 j3 k3, then m16
// - discrete form: gh opcode, i result, j k operands
// - combined form: j k joined as 6 bits
// - immediate form loads 22-bit jkm constant
// - memory form: g opcode, h index, jkm displacement
// - branch: 24-bit ijkm, i top bit clear
// - immediate 24-bit: h destination, i top set
// - j k zero give constants, no reservation
// - constants: 0, 0, 1, bit 63
// - i zero uses real register value
// - parcels enter next register, advance on issue
// - issue only without conflict, one per cycle
// - latency class follows opcode range
// - test-and-set holds while semaphore set
// - all held: flag unless monitor, exchange
// - interrupt during test-and-set: flag, flush, exchange
// - second parcel to lower register, pseudo no-op
// - substituted operands never hold issue
// - next issue waits previous issue time
//
// Local design decisions: the Avalon-MM register port and the register addresses.
`default_nettype none
module pdic_decoder
  import pdic_pkg::*;
#(
  parameter int SEMA_N = 32,
  parameter int ISSUE_CP = 1
) (
  // clock and reset
  input wire logic clock_i,
  input wire logic resetn_i,
  // avalon-mm slave
  input wire logic [2:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  // parcels from the instruction buffers
  input wire logic parcel_valid_i,
  input wire logic [15:0] parcel_i,
  input wire logic [23:0] parcel_addr_i,
  output logic parcel_ready_o,
  // register file read side
  output logic [2:0] rd_h_sel_o,
  output logic [2:0] rd_i_sel_o,
  output logic [2:0] rd_j_sel_o,
  output logic [2:0] rd_k_sel_o,
  input wire logic [63:0] rf_h_i,
  input wire logic [63:0] rf_i_i,
  input wire logic [63:0] rf_j_i,
  input wire logic [63:0] rf_k_i,
  // functional units and result returns
  input wire logic unit_busy_i,
  input wire logic [7:0] a_done_i,
  input wire logic [7:0] s_done_i,
  // issued instruction
  output logic iss_valid_o,
  output logic [6:0] iss_opcode_o,
  output logic [2:0] iss_fmt_o,
  output logic [2:0] iss_dest_o,
  output logic [23:0] iss_imm_o,
  output logic iss_var_lat_o,
  output logic [63:0] op_h_o,
  output logic [63:0] op_i_o,
  output logic [63:0] op_j_o,
  output logic [63:0] op_k_o,
  // semaphores, cluster and exchange
  input wire logic [SEMA_N-1:0] sema_i,
  input wire logic all_held_i,
  input wire logic intr_i,
  output logic tas_wait_o,
  output logic sema_set_o,
  output logic [5:0] sema_idx_o,
  output logic xchg_o,
  output logic [23:0] xchg_addr_o
);
  // ==========================================================
  // decode helpers
  function automatic logic [6:0] opc(input logic [15:0] p);
    opc = p[G_HI:H_LO];
  endfunction : opc

  function automatic logic is_mem(input logic [15:0] p);
    is_mem = p[G_HI:G_LO] >= G_MEM_LO && p[G_HI:G_LO] <= G_MEM_HI;
  endfunction : is_mem

  function automatic logic is_brimm(input logic [15:0] p);
    is_brimm = opc(p) >= OP_BR_LO && opc(p) <= OP_BR_HI;
  endfunction : is_brimm

  function automatic pdic_fmt_e fmt(input logic [15:0] p);
    if (is_mem(p) || opc(p) == OP_AIMM || opc(p) == OP_SIMM) begin
      fmt = PDIC_FMT_JKM;
    end else if (is_brimm(p)) begin
      fmt = p[I_TOP] ? PDIC_FMT_IMM24 : PDIC_FMT_BRANCH;
    end else if (opc(p) == OP_TAS || opc(p) > OP_FIX_HI) begin
      fmt = PDIC_FMT_COMBINED;
    end else begin
      fmt = PDIC_FMT_DISCRETE;
    end
  endfunction : fmt

  function automatic logic two_parcel(input logic [15:0] p);
    two_parcel = fmt(p) == PDIC_FMT_JKM || fmt(p) == PDIC_FMT_BRANCH
                 || fmt(p) == PDIC_FMT_IMM24;
  endfunction : two_parcel

  function automatic logic a_class(input logic [15:0] p);
    a_class = (opc(p) >= OP_A_LO && opc(p) <= OP_A_HI)
              || (is_mem(p) && !p[G_LO + 1]);
  endfunction : a_class

  // ==========================================================
  // pipeline registers
  logic [15:0] next_parcel_reg_r;
  logic [15:0] current_parcel_reg_r;
  logic [15:0] lower_parcel_reg_r;
  logic [23:0] nip_addr_r;
  logic [23:0] cip_addr_r;
  logic nip_v_r;
  logic cip_v_r;
  logic lip_v_r;
  logic nip_pseudo_r;
  logic cip_pseudo_r;
  logic want_lip_r;
  logic [1:0] ctrl_r;
  logic [1:0] xflags_r;
  logic [31:0] issued_r;
  logic [7:0] a_rsv_r;
  logic [7:0] s_rsv_r;
  logic [$clog2(ISSUE_CP + 1)-1:0] wait_r;
  logic [SEMA_N-1:0] sema_m_r;
  logic [SEMA_N-1:0] sema_s_r;
  logic [1:0] held_m_r;
  logic [1:0] held_s_r;
  logic issue;
  logic advance;
  logic flush;
  logic to_lip;
  logic to_nip;
  logic cip_two;
  logic cip_tas;
  logic tas_hold;
  logic opnd_ready;
  logic dest_free;
  logic writes_dest;
  logic dest_a;
  logic [2:0] dest;
  logic sema_busy;
  logic deadlock;
  logic intr_hit;
  logic [15:0] cp;
  logic [1:0] xf_set;

  // ==========================================================
  // pin synchronisers
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sema_m_r <= '0;
      sema_s_r <= '0;
      held_m_r <= 2'h0;
      held_s_r <= 2'h0;
    end else begin
      sema_m_r <= sema_i;
      sema_s_r <= sema_m_r;
      held_m_r <= {intr_i, all_held_i};
      held_s_r <= held_m_r;
    end
  end

  // ==========================================================
  // issue conditions
  assign cp = current_parcel_reg_r;
  assign cip_two = !cip_pseudo_r && two_parcel(cp);
  assign cip_tas = !cip_pseudo_r && opc(cp) == OP_TAS && cp[I_HI:I_LO] == I_TAS;
  assign sema_busy = sema_s_r[cp[J_HI:K_LO] % SEMA_N];
  assign tas_hold = cip_v_r && cip_tas && sema_busy;
  assign deadlock = tas_hold && held_s_r[0];
  assign intr_hit = tas_hold && held_s_r[1];
  assign flush = deadlock || intr_hit;
  assign dest_a = fmt(cp) == PDIC_FMT_IMM24 || a_class(cp);
  assign dest = fmt(cp) == PDIC_FMT_IMM24 ? cp[H_HI:H_LO] : cp[I_HI:I_LO];
  assign writes_dest = !cip_pseudo_r && !cip_tas && fmt(cp) != PDIC_FMT_BRANCH
                       && opc(cp) != OP_ERR && !(is_mem(cp) && cp[G_LO]);

  // register zero in h, j or k never waits on its reservation
  always_comb begin
    opnd_ready = 1'b1;
    if (fmt(cp) == PDIC_FMT_DISCRETE) begin
      if (cp[J_HI:J_LO] != 3'h0) begin
        opnd_ready = opnd_ready && !(a_class(cp) ? a_rsv_r[cp[J_HI:J_LO]]
                                                 : s_rsv_r[cp[J_HI:J_LO]]);
      end
      if (cp[K_HI:K_LO] != 3'h0) begin
        opnd_ready = opnd_ready && !(a_class(cp) ? a_rsv_r[cp[K_HI:K_LO]]
                                                 : s_rsv_r[cp[K_HI:K_LO]]);
      end
    end
    if (is_mem(cp) && cp[H_HI:H_LO] != 3'h0) begin
      opnd_ready = opnd_ready && !a_rsv_r[cp[H_HI:H_LO]];
    end
  end

  assign dest_free = !writes_dest || !(dest_a ? a_rsv_r[dest] : s_rsv_r[dest]);
  // pseudo parcel issues as a no-op, waiting only for run and issue spacing
  assign issue = cip_v_r && ctrl_r[CTRL_RUN] && wait_r == '0 && !flush
                 && (cip_pseudo_r || (!unit_busy_i && opnd_ready && dest_free
                 && (!cip_two || lip_v_r) && !tas_hold));
  assign advance = issue || !cip_v_r;
  assign to_lip = want_lip_r && !lip_v_r;
  assign to_nip = !to_lip && (!nip_v_r || advance)
                  && !(advance && nip_v_r && !nip_pseudo_r && two_parcel(next_parcel_reg_r));
  assign parcel_ready_o = !flush && (to_lip || to_nip);
  assign tas_wait_o = tas_hold;

  // ==========================================================
  // parcel pipeline
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      next_parcel_reg_r <= 16'h0;
      current_parcel_reg_r <= 16'h0;
      lower_parcel_reg_r <= 16'h0;
      nip_addr_r <= 24'h0;
      cip_addr_r <= 24'h0;
      nip_v_r <= 1'b0;
      cip_v_r <= 1'b0;
      lip_v_r <= 1'b0;
      nip_pseudo_r <= 1'b0;
      cip_pseudo_r <= 1'b0;
      want_lip_r <= 1'b0;
    end else if (flush) begin
      // exchange voids everything still waiting to issue
      nip_v_r <= 1'b0;
      cip_v_r <= 1'b0;
      lip_v_r <= 1'b0;
      want_lip_r <= 1'b0;
      nip_pseudo_r <= 1'b0;
      cip_pseudo_r <= 1'b0;
    end else begin
      if (advance) begin
        current_parcel_reg_r <= next_parcel_reg_r;
        cip_addr_r <= nip_addr_r;
        cip_v_r <= nip_v_r;
        cip_pseudo_r <= nip_pseudo_r;
        if (issue && cip_two) begin
          lip_v_r <= 1'b0;
        end
        if (nip_v_r && !nip_pseudo_r && two_parcel(next_parcel_reg_r)) begin
          next_parcel_reg_r <= 16'h0;
          nip_pseudo_r <= 1'b1;
          nip_v_r <= 1'b1;
          want_lip_r <= 1'b1;
        end else if (!(parcel_valid_i && to_nip)) begin
          nip_v_r <= 1'b0;
          nip_pseudo_r <= 1'b0;
        end
      end
      if (parcel_valid_i && to_lip) begin
        lower_parcel_reg_r <= parcel_i;
        lip_v_r <= 1'b1;
        want_lip_r <= 1'b0;
      end
      if (parcel_valid_i && to_nip) begin
        next_parcel_reg_r <= parcel_i;
        nip_addr_r <= parcel_addr_i;
        nip_v_r <= 1'b1;
        nip_pseudo_r <= 1'b0;
      end
    end
  end

  // ==========================================================
  // issue spacing and reservations
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      wait_r <= '0;
    end else if (issue) begin
      wait_r <= ($bits(wait_r))'(ISSUE_CP - 1);
    end else if (wait_r != '0) begin
      wait_r <= wait_r - 1'b1;
    end
  end

  // a result returning in the issue cycle of a new writer keeps the bit set
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      a_rsv_r <= 8'h0;
      s_rsv_r <= 8'h0;
    end else begin
      a_rsv_r <= (a_rsv_r & ~a_done_i)
                 | ((issue && writes_dest && dest_a) ? 8'h1 << dest : 8'h0);
      s_rsv_r <= (s_rsv_r & ~s_done_i)
                 | ((issue && writes_dest && !dest_a) ? 8'h1 << dest : 8'h0);
    end
  end

  // ==========================================================
  // operand fetch with register-zero constants
  assign rd_h_sel_o = cp[H_HI:H_LO];
  assign rd_i_sel_o = cp[I_HI:I_LO];
  assign rd_j_sel_o = cp[J_HI:J_LO];
  assign rd_k_sel_o = cp[K_HI:K_LO];

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      iss_valid_o <= 1'b0;
      iss_opcode_o <= 7'h0;
      iss_fmt_o <= 3'h0;
      iss_dest_o <= 3'h0;
      iss_imm_o <= 24'h0;
      iss_var_lat_o <= 1'b0;
      op_h_o <= 64'h0;
      op_i_o <= 64'h0;
      op_j_o <= 64'h0;
      op_k_o <= 64'h0;
      sema_set_o <= 1'b0;
      sema_idx_o <= 6'h0;
    end else begin
      iss_valid_o <= issue && !cip_pseudo_r;
      sema_set_o <= issue && cip_tas;
      if (issue) begin
        iss_opcode_o <= cip_pseudo_r ? OP_ERR : opc(cp);
        iss_fmt_o <= fmt(cp);
        iss_dest_o <= dest;
        sema_idx_o <= cp[J_HI:K_LO];
        unique case (fmt(cp))
          PDIC_FMT_JKM: iss_imm_o <= 24'({cp[J_HI:K_LO], lower_parcel_reg_r});
          PDIC_FMT_BRANCH, PDIC_FMT_IMM24:
            iss_imm_o <= {cp[I_HI-1:K_LO], lower_parcel_reg_r};
          PDIC_FMT_COMBINED: iss_imm_o <= 24'(cp[J_HI:K_LO]);
          PDIC_FMT_DISCRETE: iss_imm_o <= 24'h0;
          default: iss_imm_o <= 24'h0;
        endcase
        // memory, exchange and branch opcodes finish at unfixed times
        iss_var_lat_o <= !cip_pseudo_r && (is_mem(cp) || opc(cp) <= OP_BR_HI);
        op_h_o <= (cp[H_HI:H_LO] == 3'h0) ? ZERO_OPND : rf_h_i;
        op_i_o <= rf_i_i;
        op_j_o <= (cp[J_HI:J_LO] == 3'h0) ? ZERO_OPND : rf_j_i;
        op_k_o <= (cp[K_HI:K_LO] != 3'h0) ? rf_k_i
                  : (a_class(cp) ? AK_ZERO_OPND : SK_ZERO_OPND);
      end
    end
  end

  // ==========================================================
  // exchange requests
  assign xf_set = {intr_hit, deadlock && !ctrl_r[CTRL_MON]};

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      xchg_o <= 1'b0;
      xchg_addr_o <= 24'h0;
    end else begin
      xchg_o <= flush;
      if (flush) begin
        xchg_addr_o <= cip_addr_r;
      end
    end
  end

  // ==========================================================
  // avalon slave: one wait cycle, answer on the second edge
  logic ack_r;
  logic req;

  assign req = avs_read_i || avs_write_i;
  assign avs_waitrequest_o = req && !ack_r;

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ack_r <= 1'b0;
      avs_readdata_o <= 32'h0;
    end else begin
      ack_r <= req && !ack_r;
      if (avs_read_i && !ack_r) begin
        unique case (avs_address_i)
          REG_CTRL: avs_readdata_o <= 32'(ctrl_r);
          REG_STATUS: avs_readdata_o <= 32'({tas_hold, want_lip_r, lip_v_r, cip_v_r, nip_v_r});
          REG_XFLAGS: avs_readdata_o <= 32'(xflags_r);
          REG_XADDR: avs_readdata_o <= 32'(xchg_addr_o);
          REG_ISSUED: avs_readdata_o <= issued_r;
          default: avs_readdata_o <= 32'h0;
        endcase
      end
    end
  end

  // flag set by hardware wins over a same-cycle write-one-to-clear
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ctrl_r <= CTRL_RESET;
      xflags_r <= 2'h0;
      issued_r <= 32'h0;
    end else begin
      if (avs_write_i && ack_r && avs_byteenable_i[0] && avs_address_i == REG_CTRL) begin
        ctrl_r <= avs_writedata_i[1:0];
      end
      if (avs_write_i && ack_r && avs_byteenable_i[0] && avs_address_i == REG_XFLAGS) begin
        xflags_r <= (xflags_r & ~avs_writedata_i[1:0]) | xf_set;
      end else begin
        xflags_r <= xflags_r | xf_set;
      end
      if (issue && !cip_pseudo_r) begin
        issued_r <= issued_r + 32'h1;
      end
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!resetn_i);

  sequence two_issue_s;
    issue && cip_two;
  endsequence

  pseudo_nop_a: assert property (two_issue_s |=> cip_v_r && cip_pseudo_r)
    else $error("second parcel slot did not carry a pseudo no-op");
  lip_fill_a: assert property (parcel_valid_i && to_lip && !flush
                               |=> lip_v_r && !want_lip_r)
    else $error("lower parcel not captured");
  tas_hold_a: assert property (tas_hold |-> !issue)
    else $error("test-and-set issued while semaphore set");
  tas_set_a: assert property (issue && cip_tas |=> sema_set_o
                              && sema_idx_o == $past(cp[J_HI:K_LO]))
    else $error("semaphore not set on test-and-set issue");
  dest_rsv_a: assert property (issue && writes_dest
                               |=> ($past(dest_a) ? a_rsv_r[$past(dest)]
                                                  : s_rsv_r[$past(dest)]))
    else $error("destination reservation not taken");
  jzero_a: assert property (issue && cp[J_HI:J_LO] == 3'h0 |=> op_j_o == ZERO_OPND)
    else $error("j zero constant wrong");
  kzero_a: assert property (issue && cp[K_HI:K_LO] == 3'h0 && !a_class(cp)
                            |=> op_k_o == SK_ZERO_OPND)
    else $error("k zero scalar constant wrong");
  intr_flush_a: assert property (intr_hit |=> !cip_v_r && !nip_v_r && xchg_o
                                 && xchg_addr_o == $past(cip_addr_r))
    else $error("interrupt during test-and-set not exchanged");
  deadlock_a: assert property (deadlock && !ctrl_r[CTRL_MON]
                               |=> xflags_r[XF_DEADLOCK] && xchg_o)
    else $error("cluster deadlock flag missing");
  gap_a: assert property (issue && ISSUE_CP > 1 |=> !issue)
    else $error("issue spacing violated");
  bus_ans_a: assert property (req && avs_waitrequest_o |=> !avs_waitrequest_o)
    else $error("bus answer late");
endmodule : pdic_decoder
`default_nettype wire

// ===== verilog/pdic_pkg.sv
// constants, field layout and encodings for the parcel decode and issue block
// assumes a single 40 MHz clock domain shared by all users of this package
`default_nettype none
package pdic_pkg;
  // ==========================================================
  // parcel and word layout
  localparam int PARCEL_W = 16;
  localparam int ADDR_W = 24;
  localparam int WORD_PARCELS = 4;
  localparam int G_HI = 15;
  localparam int G_LO = 12;
  localparam int H_HI = 11;
  localparam int H_LO = 9;
  localparam int I_HI = 8;
  localparam int I_LO = 6;
  localparam int I_TOP = 8;
  localparam int J_HI = 5;
  localparam int J_LO = 3;
  localparam int K_HI = 2;
  localparam int K_LO = 0;
  localparam int JK_W = 6;
  localparam int JKM_W = 22;
  localparam int IJKM_W = 24;
  localparam int OPND_W = 64;
  // ==========================================================
  // operation code groups (7-bit g h value, hex)
  localparam logic [6:0] OP_ERR = 7'h00;
  localparam logic [6:0] OP_TAS = 7'h03;
  localparam logic [2:0] I_TAS = 3'h4;
  localparam logic [6:0] OP_BR_LO = 7'h06;
  localparam logic [6:0] OP_BR_HI = 7'h0f;
  localparam logic [6:0] OP_AIMM = 7'h10;
  localparam logic [6:0] OP_SIMM = 7'h20;
  localparam logic [6:0] OP_A_LO = 7'h10;
  localparam logic [6:0] OP_A_HI = 7'h1f;
  localparam logic [6:0] OP_FIX_HI = 7'h3f;
  localparam logic [6:0] OP_VEC_LO = 7'h60;
  localparam logic [3:0] G_MEM_LO = 4'h8;
  localparam logic [3:0] G_MEM_HI = 4'hb;
  // ==========================================================
  // special operand values for register zero
  localparam logic [63:0] ZERO_OPND = 64'h0;
  localparam logic [63:0] AK_ZERO_OPND = 64'h1;
  localparam logic [63:0] SK_ZERO_OPND = 64'h8000_0000_0000_0000;
  // ==========================================================
  // register map (word index on the bus)
  localparam logic [2:0] REG_CTRL = 3'h0;
  localparam logic [2:0] REG_STATUS = 3'h1;
  localparam logic [2:0] REG_XFLAGS = 3'h2;
  localparam logic [2:0] REG_XADDR = 3'h3;
  localparam logic [2:0] REG_ISSUED = 3'h4;
  localparam logic [1:0] CTRL_RESET = 2'h2;
  localparam int CTRL_MON = 0;
  localparam int CTRL_RUN = 1;
  localparam int XF_DEADLOCK = 0;
  localparam int XF_INTR = 1;
  // ==========================================================
  // instruction formats
  typedef enum logic [2:0] {
    PDIC_FMT_DISCRETE = 3'h0,
    PDIC_FMT_COMBINED = 3'h1,
    PDIC_FMT_JKM = 3'h2,
    PDIC_FMT_BRANCH = 3'h3,
    PDIC_FMT_IMM24 = 3'h4
  } pdic_fmt_e;
endpackage : pdic_pkg
`default_nettype wire
